// ---- tsc_pkg.sv ----
// Purpose: shared constants, types and helpers of the tuning synthesizer control
// Assumes: one system clock; Avalon-MM word addressing
// Notes:   register offsets are word indices
package tsc_pkg;

  localparam int REF_DIV_RATIO      = 1024;
  localparam int BCD_DIGITS         = 3;
  localparam int FINE_DIGITS        = 2;
  localparam int LOCK_FILTER_CYCLES = 4;
  localparam int ADDR_W             = 2;
  localparam int DATA_W             = 32;

  localparam logic [1:0] OFS_STATUS     = 2'h0;
  localparam logic [1:0] OFS_IRQ_ENABLE = 2'h1;
  localparam logic [1:0] OFS_IRQ_CLEAR  = 2'h2;
  localparam logic [1:0] OFS_STATE      = 2'h3;

  localparam int ST_LOCK_LOST     = 0;
  localparam int ST_LOCK_REGAINED = 1;
  localparam int ST_TUNE_STEP     = 2;
  localparam int ST_W             = 3;

  localparam int FLD_MUTE      = 0;
  localparam int FLD_DIR       = 1;
  localparam int FLD_COUNT     = 2;
  localparam int FLD_FINE_BIAS = 4;
  localparam int FLD_DIVIDE    = 8;
  localparam int FLD_FINE      = 20;

  localparam logic [ST_W-1:0] IRQ_ENABLE_RST = 3'h0;
  localparam logic [11:0]     DIVIDE_BCD_RST = 12'h507;
  localparam logic [7:0]      FINE_BCD_RST   = 8'h00;

  typedef enum logic [0:0] {
    TSC_BUS_IDLE = 1'b0,
    TSC_BUS_ACK  = 1'b1
  } tsc_bus_st_t;

  typedef enum logic [0:0] {
    TSC_LOCKED = 1'b0,
    TSC_MUTED  = 1'b1
  } tsc_lock_st_t;

  // packed bcd (4 digits) to binary
  function automatic logic [13:0] tsc_bcd_to_bin(input logic [15:0] bcd);
    logic [13:0] acc;
    acc = 14'h0000;
    for (int i = 3; i >= 0; i--) begin
      acc = 14'(acc * 14'h000A + 14'(bcd[i*4 +: 4]));
    end
    return acc;
  endfunction : tsc_bcd_to_bin

endpackage : tsc_pkg

// ---- tsc_phase_det.sv ----
// Purpose: digital phase/frequency detector with lock-failure output
// Assumes: ref_pulse and div_pulse are one-cycle pulses
// Notes:   pump is driven only while the two trains differ in phase
`timescale 1ns/1ps
module tsc_phase_det (
  input  wire logic clk,         // system clock
  input  wire logic rst_n,       // synchronised reset
  input  wire logic ref_pulse,   // reference pulse
  input  wire logic div_pulse,   // divided pulse
  output logic      pump_up,     // pump up level
  output logic      pump_dn,     // pump down level
  output logic      lock_fail_n  // low during phase difference
);
  logic up_r;
  logic up_nxt;
  logic dn_r;
  logic dn_nxt;

  always_comb begin
    up_nxt = up_r | ref_pulse;
    dn_nxt = dn_r | div_pulse;
    // both edges seen: difference ended
    if (up_nxt && dn_nxt) begin
      up_nxt = 1'b0;
      dn_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      up_r <= 1'b0;
      dn_r <= 1'b0;
    end else begin
      up_r <= up_nxt;
      dn_r <= dn_nxt;
    end
  end

  assign pump_up     = up_r;
  assign pump_dn     = dn_r;
  assign lock_fail_n = ~(up_r | dn_r);

endmodule : tsc_phase_det

// ---- tsc_encoder.sv ----
// Purpose: two-phase tuning encoder decoder and 2-bit step counter
// Assumes: phases are squared and synchronous to clk
// Notes:   counter saturates at 3; a step wins over a same-cycle clear
`timescale 1ns/1ps
module tsc_encoder (
  input  wire logic clk,             // system clock
  input  wire logic rst_n,           // synchronised reset
  input  wire logic enc_a,           // encoder phase a
  input  wire logic enc_b,           // encoder phase b
  input  wire logic clear_strobe,    // counter clear
  output logic      count_clock_a,   // pulse on phase a rise
  output logic      count_clock_b,   // pulse on phase b rise
  output logic      tune_direction,  // 1 up, 0 down
  output logic      count_bit_high,  // count bit 1
  output logic      count_bit_low    // count bit 0
);
  logic       a_prev_r, a_prev_nxt;
  logic       b_prev_r, b_prev_nxt;
  logic       ck_a_r, ck_a_nxt;
  logic       ck_b_r, ck_b_nxt;
  logic       dir_r, dir_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic [1:0] cnt_base;

  always_comb begin
    a_prev_nxt = enc_a;
    b_prev_nxt = enc_b;
    ck_a_nxt   = enc_a & ~a_prev_r;
    ck_b_nxt   = enc_b & ~b_prev_r;
    dir_nxt    = dir_r;
    cnt_base   = clear_strobe ? 2'h0 : cnt_r;
    cnt_nxt    = cnt_base;
    if (ck_a_nxt) begin
      // a leads b by a quarter turn when tuning upward
      dir_nxt = ~enc_b;
      cnt_nxt = (cnt_base == 2'h3) ? 2'h3 : 2'(cnt_base + 2'h1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      a_prev_r <= 1'b0;
      b_prev_r <= 1'b0;
      ck_a_r   <= 1'b0;
      ck_b_r   <= 1'b0;
      dir_r    <= 1'b0;
      cnt_r    <= 2'h0;
    end else begin
      a_prev_r <= a_prev_nxt;
      b_prev_r <= b_prev_nxt;
      ck_a_r   <= ck_a_nxt;
      ck_b_r   <= ck_b_nxt;
      dir_r    <= dir_nxt;
      cnt_r    <= cnt_nxt;
    end
  end

  assign count_clock_a  = ck_a_r;
  assign count_clock_b  = ck_b_r;
  assign tune_direction = dir_r;
  assign count_bit_high = cnt_r[1];
  assign count_bit_low  = cnt_r[0];

endmodule : tsc_encoder

// ---- tsc_top.sv ----
// Purpose: synthesizer digital control, lock mute, fine bias select, tuning front end
// Assumes: XTAL_IN and VCO_MIX_IN are squared, synchronous and below half the clock rate
// Notes:   registers on Avalon-MM with waitrequest, word addressed
//
// The Avalon-MM register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
// What this block does
// - The crystal input is divided by a fixed ratio into the reference pulse train.
// - A programmable counter divides its input by a BCD divide number and feeds the detector.
// - The detector emits pump pulses as wide as the phase difference and floats when locked.
// - An active-low lock-failure output is low for the duration of each phase difference.
// - Lasting lock failure disables the synthesizer output buffers.
// - The fine bias follows the offset control only in receive with offset tuning on.
// - Two quadrature encoder phases give count pulses and an up/down direction.
// - A two-bit counter holds 0 to 3 steps between clears.
// - The count is gated onto two key inputs by the sample strobe and appears there one cycle later.
// - The direction appears on a third key input, high for up.
module tsc_top
  import tsc_pkg::*;
#(
  parameter int REF_DIV   = tsc_pkg::REF_DIV_RATIO,      // reference ratio
  parameter int LOCK_CNT  = tsc_pkg::LOCK_FILTER_CYCLES  // mute filter length
) (
  input  wire logic                        CLOCK,                  // 25 MHz clock
  input  wire logic                        RST_N,                  // async reset, low
  input  wire logic                        XTAL_IN,                // crystal square wave
  input  wire logic                        VCO_MIX_IN,             // mixed vco square wave
  input  wire logic [tsc_pkg::BCD_DIGITS*4-1:0]  DIVIDE_BCD,       // divide number digits
  input  wire logic [tsc_pkg::FINE_DIGITS*4-1:0] FINE_BCD,         // fine code digits
  input  wire logic                        LATCH_STROBE,           // latch bcd digits
  input  wire logic                        RX_MODE,                // high in receive
  input  wire logic                        RECEIVE_OFFSET_TUNING,  // offset tuning on
  input  wire logic                        ENC_PHASE_A,            // encoder phase a
  input  wire logic                        ENC_PHASE_B,            // encoder phase b
  input  wire logic                        SAMPLE_SCAN_STROBE,     // count sample strobe
  input  wire logic                        CLEAR_SCAN_STROBE,      // count clear strobe
  output logic                             REF_PULSE,              // reference pulse
  output logic                             DIV_PULSE,              // divided pulse
  output logic                             PUMP_O,                 // pump drive level
  output logic                             PUMP_OE,                // pump drive enable
  output logic                             LOCK_FAIL_N,            // low on phase error
  output logic                             BUFFER_EN,              // output buffers on
  output logic [6:0]                       FINE_CRYSTAL_OSC_CODE,  // fine step 0..99
  output logic                             FINE_BIAS_FROM_OFFSET,  // bias source select
  output logic                             ENCODER_COUNT_CLOCK_A,  // count pulse a
  output logic                             ENCODER_COUNT_CLOCK_B,  // count pulse b
  output logic                             KEY_INPUT_ONE,          // count bit low gated
  output logic                             KEY_INPUT_TWO,          // count bit high gated
  output logic                             KEY_INPUT_EIGHT,        // direction gated
  input  wire logic [tsc_pkg::ADDR_W-1:0]  AVS_ADDRESS,            // word address
  input  wire logic                        AVS_READ,               // read request
  input  wire logic                        AVS_WRITE,              // write request
  input  wire logic [tsc_pkg::DATA_W-1:0]  AVS_WRITEDATA,          // write data
  output logic [tsc_pkg::DATA_W-1:0]       AVS_READDATA,           // read data
  output logic                             AVS_WAITREQUEST,        // stall
  output logic                             IRQ                     // level interrupt
);
  import tsc_pkg::*;

  localparam int RW = $clog2(REF_DIV);
  localparam int LW = $clog2(LOCK_CNT + 1);
  localparam logic [RW-1:0] REF_LAST = RW'(REF_DIV - 1);
  localparam logic [LW-1:0] LOCK_LAST = LW'(LOCK_CNT - 1);

  // reset release
  logic rst_meta_r;
  logic rst_n_s;

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_r <= 1'b0;
      rst_n_s    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_s    <= rst_meta_r;
    end
  end

  // reference divider and programmable counter
  logic          xtal_prev_r, xtal_prev_nxt;
  logic          vco_prev_r, vco_prev_nxt;
  logic [RW-1:0] ref_cnt_r, ref_cnt_nxt;
  logic          ref_pulse_r, ref_pulse_nxt;
  logic [13:0]   div_cnt_r, div_cnt_nxt;
  logic          div_pulse_r, div_pulse_nxt;
  logic [11:0]   divide_bcd_r, divide_bcd_nxt;
  logic [7:0]    fine_bcd_r, fine_bcd_nxt;
  logic [13:0]   n_bin;
  logic [13:0]   n_last;

  always_comb begin
    xtal_prev_nxt  = XTAL_IN;
    vco_prev_nxt   = VCO_MIX_IN;
    divide_bcd_nxt = LATCH_STROBE ? DIVIDE_BCD : divide_bcd_r;
    fine_bcd_nxt   = LATCH_STROBE ? FINE_BCD : fine_bcd_r;
    n_bin          = tsc_bcd_to_bin({4'h0, divide_bcd_r});
    // a divide number below two is run as two
    n_last         = (n_bin < 14'h0002) ? 14'h0001 : 14'(n_bin - 14'h0001);
    ref_cnt_nxt    = ref_cnt_r;
    ref_pulse_nxt  = 1'b0;
    if (XTAL_IN && !xtal_prev_r) begin
      ref_pulse_nxt = (ref_cnt_r == REF_LAST);
      ref_cnt_nxt   = ref_pulse_nxt ? '0 : RW'(ref_cnt_r + 1'b1);
    end
    div_cnt_nxt   = div_cnt_r;
    div_pulse_nxt = 1'b0;
    if (VCO_MIX_IN && !vco_prev_r) begin
      div_pulse_nxt = (div_cnt_r >= n_last);
      div_cnt_nxt   = div_pulse_nxt ? 14'h0000 : 14'(div_cnt_r + 14'h0001);
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      xtal_prev_r  <= 1'b0;
      vco_prev_r   <= 1'b0;
      ref_cnt_r    <= '0;
      ref_pulse_r  <= 1'b0;
      div_cnt_r    <= 14'h0000;
      div_pulse_r  <= 1'b0;
      divide_bcd_r <= DIVIDE_BCD_RST;
      fine_bcd_r   <= FINE_BCD_RST;
    end else begin
      xtal_prev_r  <= xtal_prev_nxt;
      vco_prev_r   <= vco_prev_nxt;
      ref_cnt_r    <= ref_cnt_nxt;
      ref_pulse_r  <= ref_pulse_nxt;
      div_cnt_r    <= div_cnt_nxt;
      div_pulse_r  <= div_pulse_nxt;
      divide_bcd_r <= divide_bcd_nxt;
      fine_bcd_r   <= fine_bcd_nxt;
    end
  end

  assign REF_PULSE = ref_pulse_r;
  assign DIV_PULSE = div_pulse_r;

  // phase detector
  logic pump_up;
  logic pump_dn;
  logic lock_fail_n;

  tsc_phase_det u_pd (
    .clk         (CLOCK),
    .rst_n       (rst_n_s),
    .ref_pulse   (ref_pulse_r),
    .div_pulse   (div_pulse_r),
    .pump_up     (pump_up),
    .pump_dn     (pump_dn),
    .lock_fail_n (lock_fail_n)
  );

  assign PUMP_O      = pump_up;
  assign PUMP_OE     = pump_up ^ pump_dn;
  assign LOCK_FAIL_N = lock_fail_n;

  // lock filter and mute
  tsc_lock_st_t  lock_st_r, lock_st_nxt;
  logic          err_seen_r, err_seen_nxt;
  logic [LW-1:0] err_run_r, err_run_nxt;
  logic [LW-1:0] clean_run_r, clean_run_nxt;
  logic          ev_lost, ev_regained;
  logic          bad;

  always_comb begin
    lock_st_nxt   = lock_st_r;
    err_run_nxt   = err_run_r;
    clean_run_nxt = clean_run_r;
    ev_lost       = 1'b0;
    ev_regained   = 1'b0;
    bad           = err_seen_r | ~lock_fail_n;
    // error seen since last reference; a new error beats the clear
    err_seen_nxt  = ref_pulse_r ? ~lock_fail_n : bad;
    if (ref_pulse_r) begin
      err_run_nxt   = bad ? ((err_run_r == LOCK_LAST) ? err_run_r : LW'(err_run_r + 1'b1)) : '0;
      clean_run_nxt = bad ? '0 : ((clean_run_r == LOCK_LAST) ? clean_run_r
                                                             : LW'(clean_run_r + 1'b1));
      case (lock_st_r)
        TSC_LOCKED: begin
          if (bad && err_run_r == LOCK_LAST) begin
            lock_st_nxt = TSC_MUTED;
            ev_lost     = 1'b1;
          end
        end
        TSC_MUTED: begin
          if (!bad && clean_run_r == LOCK_LAST) begin
            lock_st_nxt = TSC_LOCKED;
            ev_regained = 1'b1;
          end
        end
        default: lock_st_nxt = TSC_MUTED;
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      lock_st_r   <= TSC_MUTED;
      err_seen_r  <= 1'b0;
      err_run_r   <= '0;
      clean_run_r <= '0;
    end else begin
      lock_st_r   <= lock_st_nxt;
      err_seen_r  <= err_seen_nxt;
      err_run_r   <= err_run_nxt;
      clean_run_r <= clean_run_nxt;
    end
  end

  assign BUFFER_EN = (lock_st_r == TSC_LOCKED);

  // fine oscillator code and bias
  logic [6:0] fine_code_r, fine_code_nxt;
  logic       bias_sel_r, bias_sel_nxt;

  always_comb begin
    fine_code_nxt = 7'(tsc_bcd_to_bin({8'h00, fine_bcd_r}));
    bias_sel_nxt  = RX_MODE & RECEIVE_OFFSET_TUNING;
  end

  always_ff @(posedge CLOCK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      fine_code_r <= 7'h00;
      bias_sel_r  <= 1'b0;
    end else begin
      fine_code_r <= fine_code_nxt;
      bias_sel_r  <= bias_sel_nxt;
    end
  end

  assign FINE_CRYSTAL_OSC_CODE = fine_code_r;
  assign FINE_BIAS_FROM_OFFSET = bias_sel_r;

  // tuning encoder and key gating
  logic count_bit_high;
  logic count_bit_low;
  logic tune_direction;
  logic count_clock_a;
  logic [2:0] key_r, key_nxt;

  tsc_encoder u_enc (
    .clk            (CLOCK),
    .rst_n          (rst_n_s),
    .enc_a          (ENC_PHASE_A),
    .enc_b          (ENC_PHASE_B),
    .clear_strobe   (CLEAR_SCAN_STROBE),
    .count_clock_a  (count_clock_a),
    .count_clock_b  (ENCODER_COUNT_CLOCK_B),
    .tune_direction (tune_direction),
    .count_bit_high (count_bit_high),
    .count_bit_low  (count_bit_low)
  );

  always_comb begin
    key_nxt[0] = SAMPLE_SCAN_STROBE & count_bit_low;
    key_nxt[1] = SAMPLE_SCAN_STROBE & count_bit_high;
    key_nxt[2] = SAMPLE_SCAN_STROBE & tune_direction;
  end

  always_ff @(posedge CLOCK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      key_r <= 3'h0;
    end else begin
      key_r <= key_nxt;
    end
  end

  assign ENCODER_COUNT_CLOCK_A = count_clock_a;
  assign KEY_INPUT_ONE         = key_r[0];
  assign KEY_INPUT_TWO         = key_r[1];
  assign KEY_INPUT_EIGHT       = key_r[2];

  // register bus and interrupts
  tsc_bus_st_t         bus_st_r, bus_st_nxt;
  logic [DATA_W-1:0]   rdata_r, rdata_nxt;
  logic [ST_W-1:0]     status_r, status_nxt;
  logic [ST_W-1:0]     irq_en_r, irq_en_nxt;
  logic [ST_W-1:0]     events;
  logic [ST_W-1:0]     clr_mask;
  logic [DATA_W-1:0]   state_word;
  logic                req;
  logic                wr_done;

  always_comb begin
    req        = AVS_READ | AVS_WRITE;
    wr_done    = AVS_WRITE & (bus_st_r == TSC_BUS_ACK);
    events     = '0;
    events[ST_LOCK_LOST]     = ev_lost;
    events[ST_LOCK_REGAINED] = ev_regained;
    events[ST_TUNE_STEP]     = count_clock_a;
    clr_mask   = (wr_done && AVS_ADDRESS == OFS_IRQ_CLEAR) ? AVS_WRITEDATA[ST_W-1:0] : '0;
    // new events win over a same-cycle clear
    status_nxt = (status_r & ~clr_mask) | events;
    irq_en_nxt = (wr_done && AVS_ADDRESS == OFS_IRQ_ENABLE) ? AVS_WRITEDATA[ST_W-1:0]
                                                            : irq_en_r;
    state_word = '0;
    state_word[FLD_MUTE]           = (lock_st_r == TSC_MUTED);
    state_word[FLD_DIR]            = tune_direction;
    state_word[FLD_COUNT +: 2]     = {count_bit_high, count_bit_low};
    state_word[FLD_FINE_BIAS]      = bias_sel_r;
    state_word[FLD_DIVIDE +: 12]   = divide_bcd_r;
    state_word[FLD_FINE +: 8]      = fine_bcd_r;
    rdata_nxt  = rdata_r;
    bus_st_nxt = TSC_BUS_IDLE;
    case (bus_st_r)
      TSC_BUS_IDLE: begin
        if (req) begin
          bus_st_nxt = TSC_BUS_ACK;
          rdata_nxt  = '0;
          if (AVS_READ) begin
            case (AVS_ADDRESS)
              OFS_STATUS:     rdata_nxt[ST_W-1:0] = status_r;
              OFS_IRQ_ENABLE: rdata_nxt[ST_W-1:0] = irq_en_r;
              OFS_STATE:      rdata_nxt           = state_word;
              default:        rdata_nxt           = '0;
            endcase
          end
        end
      end
      TSC_BUS_ACK: bus_st_nxt = TSC_BUS_IDLE;
      default:     bus_st_nxt = TSC_BUS_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      bus_st_r <= TSC_BUS_IDLE;
      rdata_r  <= '0;
      status_r <= '0;
      irq_en_r <= IRQ_ENABLE_RST;
    end else begin
      bus_st_r <= bus_st_nxt;
      rdata_r  <= rdata_nxt;
      status_r <= status_nxt;
      irq_en_r <= irq_en_nxt;
    end
  end

  assign AVS_WAITREQUEST = req & (bus_st_r == TSC_BUS_IDLE);
  assign AVS_READDATA    = rdata_r;
  assign IRQ             = |(status_r & irq_en_r);

endmodule : tsc_top

// ---- tsc_top_properties.sv ----
// Purpose: port checks of tsc_top
// Assumes: one clock, RST_N low resets all
// Notes:   bound into every tsc_top
`timescale 1ns/1ps
module tsc_top_properties
  import tsc_pkg::*;
#(
  parameter int REF_DIV  = tsc_pkg::REF_DIV_RATIO,      // reference ratio
  parameter int LOCK_CNT = tsc_pkg::LOCK_FILTER_CYCLES  // mute filter
) (
  input wire logic CLOCK,                  // clock
  input wire logic RST_N,                  // reset
  input wire logic RX_MODE,                // receive
  input wire logic RECEIVE_OFFSET_TUNING,  // offset on
  input wire logic ENC_PHASE_A,            // phase a
  input wire logic SAMPLE_SCAN_STROBE,     // sample
  input wire logic REF_PULSE,              // reference
  input wire logic DIV_PULSE,              // divided
  input wire logic PUMP_OE,                // pump enable
  input wire logic LOCK_FAIL_N,            // lock fail
  input wire logic BUFFER_EN,              // buffers on
  input wire logic FINE_BIAS_FROM_OFFSET,  // bias select
  input wire logic ENCODER_COUNT_CLOCK_A,  // count pulse
  input wire logic KEY_INPUT_ONE,          // key 1
  input wire logic KEY_INPUT_TWO,          // key 2
  input wire logic KEY_INPUT_EIGHT,        // key 8
  input wire logic AVS_READ,               // read
  input wire logic AVS_WRITE,              // write
  input wire logic AVS_WAITREQUEST         // stall
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  keys_gated_a: assert property (!SAMPLE_SCAN_STROBE |=> !KEY_INPUT_ONE && !KEY_INPUT_TWO
    && !KEY_INPUT_EIGHT) else $error("keys without strobe");
  bias_select_a: assert property (1 |=> FINE_BIAS_FROM_OFFSET == $past(RX_MODE
    && RECEIVE_OFFSET_TUNING)) else $error("bias select wrong");
  pump_float_a: assert property (PUMP_OE |-> !LOCK_FAIL_N) else $error("pump driven in lock");
  ref_single_a: assert property (REF_PULSE |=> !REF_PULSE) else $error("reference pulse long");
  div_single_a: assert property (DIV_PULSE |=> !DIV_PULSE) else $error("divided pulse long");
  count_clock_a: assert property ($rose(ENC_PHASE_A) |=> ENCODER_COUNT_CLOCK_A)
    else $error("no count pulse");
  bus_ack_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("no bus answer");
  mute_step_a: assert property ($changed(BUFFER_EN) |-> $past(REF_PULSE)
    || $past(REF_PULSE, 2) || $past(REF_PULSE, 3)) else $error("mute off reference");
  lock_seen_c: cover property ($rose(BUFFER_EN));
  tune_up_c: cover property (KEY_INPUT_EIGHT);
  full_count_c: cover property (KEY_INPUT_ONE && KEY_INPUT_TWO);
endmodule : tsc_top_properties
bind tsc_top tsc_top_properties #(.REF_DIV(REF_DIV), .LOCK_CNT(LOCK_CNT)) i_tsc_top_properties (
  .CLOCK(CLOCK), .RST_N(RST_N), .RX_MODE(RX_MODE), .ENC_PHASE_A(ENC_PHASE_A),
  .RECEIVE_OFFSET_TUNING(RECEIVE_OFFSET_TUNING), .SAMPLE_SCAN_STROBE(SAMPLE_SCAN_STROBE),
  .REF_PULSE(REF_PULSE), .DIV_PULSE(DIV_PULSE), .PUMP_OE(PUMP_OE), .LOCK_FAIL_N(LOCK_FAIL_N),
  .BUFFER_EN(BUFFER_EN), .FINE_BIAS_FROM_OFFSET(FINE_BIAS_FROM_OFFSET),
  .ENCODER_COUNT_CLOCK_A(ENCODER_COUNT_CLOCK_A), .KEY_INPUT_ONE(KEY_INPUT_ONE),
  .KEY_INPUT_TWO(KEY_INPUT_TWO), .KEY_INPUT_EIGHT(KEY_INPUT_EIGHT), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST));

// ---- tsc_ctrl_model.sv ----
// Purpose: control computer: scan, tune, bcd output
// Assumes: keys valid one cycle after strobe
// Notes:   frequency kept in 100 Hz units
`timescale 1ns/1ps
module tsc_ctrl_model (
  input  wire logic        clk,          // clock
  input  wire logic        rst_n,        // reset
  input  wire logic        key_one,      // count bit 0
  input  wire logic        key_two,      // count bit 1
  input  wire logic        key_eight,    // up
  input  wire logic        scan_req,     // start scan
  input  wire logic        preset_en,    // load preset
  input  wire logic [19:0] preset_freq,  // preset value
  output logic      [11:0] divide_bcd,   // divide number
  output logic      [7:0]  fine_bcd,     // fine code
  output logic             latch,        // latch strobe
  output logic             sample,       // sample strobe
  output logic             clear         // clear strobe
);
  logic [2:0]  st_r;
  logic [19:0] freq_r;
  int          n;
  int          f;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r   <= 3'h4;      // clear then latch after start-up
      freq_r <= 20'h7A508; // 50.1 MHz
    end else begin
      if (preset_en)
        freq_r <= preset_freq;
      if (st_r == 3'h3)
        freq_r <= key_eight ? freq_r + 20'({key_two, key_one})
                            : freq_r - 20'({key_two, key_one});
      st_r <= (st_r == 3'h6) ? 3'h0 : (st_r != 3'h0 || scan_req) ? st_r + 3'h1 : 3'h0;
    end
  end
  always_comb begin
    n = int'(freq_r) / 100 - 5000 + 497;
    f = int'(freq_r) % 100;              // carry into n at rollover
    divide_bcd = {4'(n / 100), 4'(n / 10 % 10), 4'(n % 10)};
    fine_bcd = {4'(f / 10), 4'(f % 10)};
  end
  assign sample = st_r inside {3'h1, 3'h2, 3'h3};
  assign clear  = st_r == 3'h4;
  assign latch  = st_r == 3'h5;
endmodule : tsc_ctrl_model

// ---- tsc_top_tb.sv ----
// Purpose: self-checking bench of tsc_top
// Assumes: REF_DIV 8, LOCK_CNT 2, crystal at clock/4
// Notes:   lock search slips vco phase
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin fails++; \
  $display("BAD %s exp %0h got %0h", nm, e, s); end end
module tsc_top_tb;
  import tsc_pkg::*;
  logic CLOCK = 0, RST_N = 0, XTAL_IN = 0, VCO_MIX_IN = 0, RX_MODE = 0, ROT = 0;
  logic ENC_A = 0, ENC_B = 0, RD = 0, WR = 0, vco_skip = 0, scan_req = 0, preset_en = 0;
  logic [1:0]  ADDR = 0;
  logic [31:0] WDATA = 0, RDATA, rdat;
  logic [19:0] preset_freq = 0;
  logic [11:0] DIV_BCD;
  logic [7:0]  FINE_BCD;
  logic [6:0]  FINE_CODE;
  logic [3:0]  ctr = 0;
  logic LATCH, SAMPLE, CLR, REF_P, DIV_P, PUMP, PUMP_OE, LFAIL_N, BUF_EN, BIAS, CKA, CKB;
  logic K1, K2, K8, WAIT, IRQ;
  int   fails = 0, n_compared = 0, c;
  tsc_top #(.REF_DIV(8), .LOCK_CNT(2)) i_tsc_top (.CLOCK(CLOCK), .RST_N(RST_N),
    .XTAL_IN(XTAL_IN), .VCO_MIX_IN(VCO_MIX_IN), .DIVIDE_BCD(DIV_BCD), .FINE_BCD(FINE_BCD),
    .LATCH_STROBE(LATCH), .RX_MODE(RX_MODE), .RECEIVE_OFFSET_TUNING(ROT), .ENC_PHASE_A(ENC_A),
    .ENC_PHASE_B(ENC_B), .SAMPLE_SCAN_STROBE(SAMPLE), .CLEAR_SCAN_STROBE(CLR),
    .REF_PULSE(REF_P), .DIV_PULSE(DIV_P), .PUMP_O(PUMP), .PUMP_OE(PUMP_OE),
    .LOCK_FAIL_N(LFAIL_N), .BUFFER_EN(BUF_EN), .FINE_CRYSTAL_OSC_CODE(FINE_CODE),
    .FINE_BIAS_FROM_OFFSET(BIAS), .ENCODER_COUNT_CLOCK_A(CKA), .ENCODER_COUNT_CLOCK_B(CKB),
    .KEY_INPUT_ONE(K1), .KEY_INPUT_TWO(K2), .KEY_INPUT_EIGHT(K8), .AVS_ADDRESS(ADDR),
    .AVS_READ(RD), .AVS_WRITE(WR), .AVS_WRITEDATA(WDATA), .AVS_READDATA(RDATA),
    .AVS_WAITREQUEST(WAIT), .IRQ(IRQ));
  tsc_ctrl_model i_tsc_ctrl_model (.clk(CLOCK), .rst_n(RST_N), .key_one(K1), .key_two(K2),
    .key_eight(K8), .scan_req(scan_req), .preset_en(preset_en), .preset_freq(preset_freq),
    .divide_bcd(DIV_BCD), .fine_bcd(FINE_BCD), .latch(LATCH), .sample(SAMPLE), .clear(CLR));
  initial forever #20 CLOCK = ~CLOCK;
  always @(posedge CLOCK) begin
    ctr <= ctr + 4'h1;
    XTAL_IN <= ctr[1];
    VCO_MIX_IN <= ctr[1] && !vco_skip;
  end
  task automatic bus(input logic w, input logic [1:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    RD <= !w;
    WR <= w;
    ADDR <= a;
    WDATA <= d;
    do @(negedge CLOCK); while (WAIT !== 1'b0);
    @(posedge CLOCK) rdat = RDATA;
    RD <= 1'b0;
    WR <= 1'b0;
  endtask : bus
  task automatic enc(input int n, input logic up);
    repeat (n) begin
      @(posedge CLOCK) ENC_B <= !up;
      @(posedge CLOCK) ENC_A <= 1'b1;
      repeat (2) @(posedge CLOCK);
      ENC_A <= 1'b0;
    end
    @(posedge CLOCK) scan_req <= 1'b1;
    @(posedge CLOCK) scan_req <= 1'b0;
    repeat (10) @(posedge CLOCK);
  endtask : enc
  task automatic gap(input logic sel);
    while ((sel ? DIV_P : REF_P) !== 1'b1) @(posedge CLOCK);
    c = 0;
    do begin @(posedge CLOCK); c++; end while ((sel ? DIV_P : REF_P) !== 1'b1);
  endtask : gap
  task automatic t_defaults();
    bus(1'b0, OFS_STATE, 32'h0);
    `CHK("divide", 12'h507, rdat[FLD_DIVIDE +: 12])
    `CHK("muted", 1'b1, rdat[FLD_MUTE])
    bus(1'b0, OFS_IRQ_ENABLE, 32'h0);
    `CHK("irq_enable", 32'h0, rdat)
    $display("done defaults");
  endtask : t_defaults
  task automatic t_tune();
    @(posedge CLOCK) preset_en <= 1'b1;
    preset_freq <= 20'h6E27E;
    @(posedge CLOCK) preset_en <= 1'b0;
    enc(5, 1'b1);
    `CHK("fine_up", 7'h01, FINE_CODE)
    bus(1'b0, OFS_STATE, 32'h0);
    `CHK("divide_up", 12'h009, rdat[FLD_DIVIDE +: 12])
    bus(1'b0, OFS_STATUS, 32'h0);
    `CHK("step_event", 1'b1, rdat[ST_TUNE_STEP])
    enc(2, 1'b0);
    `CHK("fine_down", 7'h63, FINE_CODE)
    bus(1'b0, OFS_STATE, 32'h0);
    `CHK("divide_down", 12'h008, rdat[FLD_DIVIDE +: 12])
    $display("done tune");
  endtask : t_tune
  task automatic t_bias();
    for (int i = 0; i < 4; i++) begin
      @(posedge CLOCK) {RX_MODE, ROT} <= 2'(i);
      repeat (3) @(posedge CLOCK);
      `CHK("bias", i == 3, BIAS)
    end
    $display("done bias");
  endtask : t_bias
  task automatic t_lock();
    for (int k = 0; k < 9 && BUF_EN !== 1'b1; k++) begin
      repeat (256) @(posedge CLOCK);
      while (ctr[1:0] !== 2'h3) @(posedge CLOCK);
      vco_skip <= BUF_EN !== 1'b1;
      repeat (4) @(posedge CLOCK);
      vco_skip <= 1'b0;
    end
    `CHK("locked", 1'b1, BUF_EN)
    gap(1'b0);
    `CHK("ref_period", 32, c)
    gap(1'b1);
    `CHK("div_period", 32, c)
    bus(1'b1, OFS_IRQ_CLEAR, 32'h7);
    bus(1'b1, OFS_IRQ_ENABLE, 32'h1);
    vco_skip <= 1'b1;
    repeat (170) @(posedge CLOCK);
    `CHK("lock_fail", 1'b0, LFAIL_N)
    `CHK("pump", 2'h3, {PUMP_OE, PUMP})
    `CHK("muted", 1'b0, BUF_EN)
    `CHK("irq_set", 1'b1, IRQ)
    bus(1'b1, OFS_IRQ_CLEAR, 32'h1);
    bus(1'b0, OFS_IRQ_CLEAR, 32'h0);
    `CHK("clear_reads_0", 32'h0, rdat)
    `CHK("irq_cleared", 1'b0, IRQ)
    $display("done lock");
  endtask : t_lock
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    #800000;
    fails++;
    end_of_test();
  end
  initial begin
    repeat (2) @(posedge CLOCK);
    RST_N <= 1'b1;
    repeat (3) @(posedge CLOCK);
    t_defaults();
    t_tune();
    t_bias();
    t_lock();
    end_of_test();
  end
endmodule : tsc_top_tb
